/* src/pcd_pkg.sv */
// Constants shared by the programmable clock divider block.
// Assumes one 200 MHz sampling clock; reference clocks arrive as levels.
`default_nettype none
package pcd_pkg;
   localparam int WORD_W = 9;
   localparam int CNT_W = 10;
   localparam int CFG_W = 18;
   // Mode word bit positions
   localparam int REFSRC_BIT = 0;
   localparam int DIRECT_BIT = 1;
   localparam int BYPASS_BIT = 2;
   localparam int RATIO_BIT = 3;
   localparam int PINFN_BIT = 4;
   localparam int REFDIS_BIT = 5;
   // Divisor is the programmed value plus this offset
   localparam logic [CNT_W-1:0] DIV_OFFSET = 10'h002;
   // Prescaler values fed to a divider instance (offset added there)
   localparam logic [WORD_W-1:0] PRESCALE_BY4 = 9'h002;
   localparam logic [WORD_W-1:0] PRESCALE_BY2 = 9'h000;
   // Storage contents before any write command
   localparam logic [WORD_W-1:0] MODE_FACTORY = 9'h000;
   localparam logic [WORD_W-1:0] DIV_FACTORY = 9'h000;
   localparam logic [WORD_W-1:0] WORD_ZERO = 9'h000;
   localparam logic [CFG_W-1:0] SHIFT_ZERO = 18'h00000;
   localparam real CLK_MHZ = 200.0;
   typedef enum logic [1:0] {
      PD_RUN,
      PD_GATE_MAIN,
      PD_GATE_REF,
      PD_OFF
   } pcd_pd_e;
endpackage
`default_nettype wire

/* src/pcd_divider.sv */
// Divide-by-(value+2) counter advanced by a one-cycle tick.
// Assumes tick is a rising-edge pulse of the clock being divided.
`default_nettype none
module pcd_divider #(
   parameter int W = pcd_pkg::WORD_W,
   parameter int CW = pcd_pkg::CNT_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Control
   input wire logic tick,
   input wire logic hold,
   input wire logic [W-1:0] value,
   // Result
   output logic divOut
);
   import pcd_pkg::*;
   logic [CW-1:0] cnt;
   logic [CW-1:0] divisor;
   logic [CW-1:0] lastCnt;
   logic [CW-1:0] next_cnt;

   assign divisor = CW'(value) + DIV_OFFSET;
   assign lastCnt = divisor - 10'h001;
   assign next_cnt = (cnt >= lastCnt) ? '0 : cnt + 10'h001;

   // Held counter parks at the last count so the first tick restarts at 0
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= '0;
         divOut <= 1'b0;
      end else if (hold) begin
         cnt <= lastCnt;
         divOut <= 1'b0;
      end else if (tick) begin
         cnt <= next_cnt;
         divOut <= next_cnt < (divisor >> 1);
      end
   end
endmodule
`default_nettype wire

/* src/pcd_clock_divider.sv */
// Top of the programmable clock divider: config load, reference select,
// prescaler, divider, synchronous gating and power-down sequencing.
// Assumes reference clocks are far slower than ref_clk and are sampled.
`default_nettype none
// Operation
// - In program mode the shared pin shifts serial config in; write commits.
// - In operating mode config reloads from storage; pin is main output.
// - Config changes only at power-up, never during operation.
// - Config is two nine-bit words: mode word and divider value.
// - With pin function 1, source bit picks external (1) or internal (0).
// - With pin function 0, pin low picks external, high picks internal.
// - With pin function 1, pin low powers down and stops oscillation.
// - Power-down gates main output, then reference output, then oscillator; refGate can drop first, at any master clock low once PD_RUN is left.
// - Enable low holds main output low, waiting for its falling edge.
// - While gated, oscillator and prescaler run; main divider counter is held at its last count.
// - After enable returns, first main edge within one to two periods.
// - Reference output follows select mux, ignores enable, gated in power-down.
// - Reference disable bit set turns the reference output off for good.
// - Direct route sends reference straight out; internal skips prescaler.
// - Bypass bit skips prescaler when 1; direct route set skips it too.
// - Ratio bit picks divide by 4 at 0, by 2 at 1.
// - Divider divides by programmed value plus two, 2 to 513.
// - Enable sampled on the selected master clock, gated with divider output.
// - Internal to external switch detected on internal clock falling edge.
module pcd_clock_divider (
   // Clock and power-up reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Straps and control pins
   input wire logic programMode,
   input wire logic outputEnable,
   input wire logic powerdownOrRefPin,
   // Reference sources
   input wire logic onChipOsc,
   input wire logic extRefIn,
   // Serial programming port
   input wire logic serialStrobe,
   input wire logic writeCmd,
   // Shared input/output pin
   input wire logic ioIn,
   output logic ioOut,
   output logic ioOe,
   // Reference clock output
   output logic refClockOut,
   output logic refOutOe,
   // Oscillator power control
   output logic oscEnable
);
   import pcd_pkg::*;

   logic bootDone;
   logic progLatched;
   logic [WORD_W-1:0] nvMode = MODE_FACTORY;
   logic [WORD_W-1:0] nvDiv = DIV_FACTORY;
   logic [CFG_W-1:0] shiftReg;
   logic [WORD_W-1:0] modeWord;
   logic [WORD_W-1:0] divWord;
   logic oscPrev;
   logic oscTick;
   logic intPrescaled;
   logic int_ref_clock;
   logic intPrev;
   logic curExt;
   logic pendSw;
   logic intFellSeen;
   logic wantExt;
   logic mclk;
   logic mclkLvl;
   logic mclkPrev;
   logic mclkTick;
   logic oeSamp;
   logic gateOn;
   logic refGate;
   logic divOut;
   logic mainLvl;
   logic pdReq;
   logic running;
   pcd_pd_e pdState;

   // Strap caught after reset release; storage kept across resets
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         bootDone <= 1'b0;
         progLatched <= 1'b0;
         modeWord <= WORD_ZERO;
         divWord <= WORD_ZERO;
      end else if (!bootDone) begin
         bootDone <= 1'b1;
         progLatched <= programMode;
         modeWord <= nvMode;
         divWord <= nvDiv;
      end
   end

   // Serial load: mode word first, MSB first, then divider value
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         shiftReg <= SHIFT_ZERO;
      else if (bootDone && progLatched && serialStrobe)
         shiftReg <= {shiftReg[CFG_W-2:0], ioIn};
   end

   // Commit only; live config never follows storage until next power-up
   always_ff @(posedge ref_clk) begin
      if (bootDone && progLatched && writeCmd) begin
         nvMode <= shiftReg[CFG_W-1:WORD_W];
         nvDiv <= shiftReg[WORD_W-1:0];
      end
   end

   assign running = bootDone && !progLatched;
   assign oscTick = onChipOsc && !oscPrev;

   // Prescaler on the internal oscillator, reusing the divider
   pcd_divider #(.W(WORD_W), .CW(CNT_W)) prescaler (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .tick(oscTick),
      .hold(!running),
      .value(modeWord[RATIO_BIT] ? PRESCALE_BY2 : PRESCALE_BY4),
      .divOut(intPrescaled)
   );

   // Internal clock skips prescaler on bypass or direct route
   assign int_ref_clock = (modeWord[BYPASS_BIT] || modeWord[DIRECT_BIT]) ?
                   onChipOsc : intPrescaled;

   // Source wanted by the pin or the stored bit
   always_comb begin
      if (modeWord[PINFN_BIT])
         wantExt = modeWord[REFSRC_BIT];
      else
         wantExt = !powerdownOrRefPin;
   end

   // Glitch-free switch: mux output held low while a switch is pending
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         oscPrev <= 1'b0;
         intPrev <= 1'b0;
         curExt <= 1'b0;
         pendSw <= 1'b0;
         intFellSeen <= 1'b0;
      end else begin
         oscPrev <= onChipOsc;
         intPrev <= int_ref_clock;
         if (!running) begin
            curExt <= wantExt;
            pendSw <= 1'b0;
            intFellSeen <= 1'b0;
         end else if (wantExt != curExt && !pendSw) begin
            pendSw <= 1'b1;
            intFellSeen <= 1'b0;
         end else if (pendSw && wantExt == curExt) begin
            pendSw <= 1'b0;
         end else if (pendSw && wantExt) begin
            // Edge on the internal clock, then wait for external low
            if (intPrev && !int_ref_clock)
               intFellSeen <= 1'b1;
            if (intFellSeen && !extRefIn) begin
               curExt <= 1'b1;
               pendSw <= 1'b0;
            end
         end else if (pendSw) begin
            // Level triggered: external low, then internal falling edge
            if (!extRefIn)
               intFellSeen <= 1'b1;
            if (intFellSeen && intPrev && !int_ref_clock) begin
               curExt <= 1'b0;
               pendSw <= 1'b0;
            end
         end
      end
   end

   assign mclk = !pendSw && (curExt ? extRefIn : int_ref_clock);
   assign mclkTick = mclkLvl && !mclkPrev;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mclkLvl <= 1'b0;
         mclkPrev <= 1'b0;
      end else begin
         mclkLvl <= mclk && running && oscEnable;
         mclkPrev <= mclkLvl;
      end
   end

   // Enable sampled on the master clock rising edge
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         oeSamp <= 1'b0;
      else if (mclkTick)
         oeSamp <= outputEnable;
   end

   pcd_divider #(.W(WORD_W), .CW(CNT_W)) main_divider (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .tick(mclkTick),
      .hold(!gateOn),
      .value(divWord),
      .divOut(divOut)
   );

   assign mainLvl = modeWord[DIRECT_BIT] ? mclkLvl : divOut;

   // Gate closes only while the output is low, so no pulse is cut
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         gateOn <= 1'b0;
      else if (!running)
         gateOn <= 1'b0;
      else if (oeSamp && pdState == PD_RUN)
         gateOn <= 1'b1;
      else if (!mainLvl)
         gateOn <= 1'b0;
   end

   assign pdReq = modeWord[PINFN_BIT] && !powerdownOrRefPin;

   // Power-down sequencer
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pdState <= PD_RUN;
      end else if (!running) begin
         pdState <= PD_RUN;
      end else begin
         unique case (pdState)
            PD_RUN:
               if (pdReq)
                  pdState <= PD_GATE_MAIN;
            PD_GATE_MAIN:
               if (!gateOn)
                  pdState <= PD_GATE_REF;
            PD_GATE_REF:
               if (!refGate)
                  pdState <= PD_OFF;
            PD_OFF:
               if (!pdReq)
                  pdState <= PD_RUN;
         endcase
      end
   end

   // Reference gate drops while the master clock is low
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         refGate <= 1'b0;
      else if (!running || modeWord[REFDIS_BIT])
         refGate <= 1'b0;
      else if (pdState == PD_RUN)
         refGate <= 1'b1;
      else if (!mclkLvl)
         refGate <= 1'b0;
   end

   // Pins; the shared pin drives only in operating mode
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ioOut <= 1'b0;
         ioOe <= 1'b0;
         refClockOut <= 1'b0;
         refOutOe <= 1'b0;
         oscEnable <= 1'b1;
      end else begin
         ioOut <= gateOn && mainLvl;
         ioOe <= running && pdState != PD_OFF;
         refClockOut <= refGate && mclkLvl;
         refOutOe <= running && !modeWord[REFDIS_BIT] &&
                     pdState != PD_OFF;
         oscEnable <= !(running && pdState == PD_OFF);
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   prog_pin_input_a: assert property (
      progLatched |-> !ioOe)
      else $error("shared pin driven in program mode");

   config_frozen_a: assert property (
      bootDone && $past(bootDone) |-> $stable(modeWord) && $stable(divWord))
      else $error("configuration changed during operation");

   ref_disable_a: assert property (
      modeWord[REFDIS_BIT] |-> !refOutOe && !refClockOut)
      else $error("reference output active while disabled");

   pd_stop_a: assert property (
      running && pdState == PD_OFF |=> !oscEnable && !ioOe && !refOutOe)
      else $error("power-down did not stop outputs and oscillator");

   pd_order_a: assert property (
      pdState == PD_GATE_REF |-> !gateOn && !ioOut)
      else $error("reference gated before main output");

   no_truncate_a: assert property (
      $fell(gateOn) |-> !$past(mainLvl))
      else $error("main gate closed during a high pulse");

   held_counter_a: assert property (
      !gateOn ##1 !gateOn |-> !divOut)
      else $error("divider ran while output gated");

   source_bit_a: assert property (
      running && $past(running) && modeWord[PINFN_BIT] && !pendSw |->
      curExt == modeWord[REFSRC_BIT])
      else $error("reference source bit not honoured");

   switch_pending_a: assert property (
      running && $past(running) && $changed(curExt) |->
      $past(pendSw) && !mclkLvl)
      else $error("reference switched without holding low");

   ref_follows_a: assert property (
      refGate && $past(refGate) |-> refClockOut == $past(mclkLvl))
      else $error("reference output does not follow master clock");
endmodule
`default_nettype wire

/* testbench/pcd_board_model.sv */
// Board logic that takes the main clock and times its pulses.
// Assumes ioOut is sampled on the same ref_clk as the block's logic.
`default_nettype none
module pcd_board_model (
   // Clock
   input wire logic ref_clk,
   // Main clock pin
   input wire logic ioOut,
   input wire logic ioOe,
   // Measurements in ref_clk cycles
   output int period,
   output int highLen,
   output int rises
);
   int cnt = 0;
   int hcnt = 0;
   logic last = 1'b0;
   // Only a driven pin counts a rise; a floating one is not a clock
   always @(posedge ref_clk) begin
      last <= ioOut;
      cnt <= cnt + 1;
      if (ioOe && ioOut && !last) begin
         period <= cnt;
         cnt <= 1;
         rises <= rises + 1;
      end
      if (ioOut) hcnt <= hcnt + 1;
      if (!ioOut && last) begin
         highLen <= hcnt;
         hcnt <= 0;
      end
   end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the clock divider: programs, power cycles,
// then times the main clock. Internal osc period 8, external 12.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pcd_pkg::*;
   logic ref_clk = 1'b0, rst_b = 1'b0, programMode = 1'b0;
   logic outputEnable = 1'b1, powerdownOrRefPin = 1'b1;
   logic onChipOsc = 1'b0, extRefIn = 1'b0, progBit = 1'b0;
   logic serialStrobe = 1'b0, writeCmd = 1'b0;
   logic ioOut, ioOe, refClockOut, refOutOe, oscEnable;
   wire logic ioIn;
   int period, highLen, rises, r0, n, hi, tog;
   int fails = 0;
   int cmp_count = 0;
   int phase = 0;
   // Shared pin: the block wins while it drives
   assign ioIn = ioOe ? ioOut : progBit;
   always #2.5 ref_clk = ~ref_clk;
   // Oscillator stops while powered down
   always @(posedge ref_clk) begin
      phase <= phase + 1;
      onChipOsc <= oscEnable && (phase % 8) >= 4;
      extRefIn <= (phase % 12) >= 6;
   end
   pcd_clock_divider i_pcd_clock_divider (.ref_clk(ref_clk),
      .rst_b(rst_b), .programMode(programMode),
      .outputEnable(outputEnable), .powerdownOrRefPin(powerdownOrRefPin),
      .onChipOsc(onChipOsc), .extRefIn(extRefIn),
      .serialStrobe(serialStrobe), .writeCmd(writeCmd), .ioIn(ioIn),
      .ioOut(ioOut), .ioOe(ioOe), .refClockOut(refClockOut),
      .refOutOe(refOutOe), .oscEnable(oscEnable));
   pcd_board_model i_pcd_board_model (.ref_clk(ref_clk), .ioOut(ioOut),
      .ioOe(ioOe), .period(period), .highLen(highLen), .rises(rises));
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (fails == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   // Bounded wait on a level of the main or oscillator output
   task automatic await(input int sel, input logic lvl);
      n = 0;
      while ((sel ? oscEnable : ioOut) !== lvl) begin
         cyc(1);
         n++;
         if (n > 5000) begin
            check("wait bound", 1'b0, 1'b1);
            finish_test();
         end
      end
   endtask
   task automatic power_up(input logic prog);
      rst_b <= 1'b0;
      programMode <= prog;
      cyc(8);
      rst_b <= 1'b1;
      cyc(3);
   endtask
   task automatic shift_frame(input logic [17:0] frame);
      for (int i = 17; i >= 0; i--) begin
         serialStrobe <= 1'b1;
         progBit <= frame[i];
         cyc(1);
      end
      serialStrobe <= 1'b0;
      writeCmd <= 1'b1;
      cyc(1);
      writeCmd <= 1'b0;
      cyc(2);
   endtask
   task automatic run_case(input logic [8:0] mode, input logic [8:0] nv,
                           input logic pin, input int ep, input int eh);
      powerdownOrRefPin <= 1'b1;
      power_up(1'b1);
      check("ioOe in program", ioOe, 1'b0);
      shift_frame({mode, nv});
      powerdownOrRefPin <= pin;
      power_up(1'b0);
      check("ioOe in run", ioOe, 1'b1);
      check("ref enable", refOutOe, !mode[REFDIS_BIT]);
      r0 = rises;
      cyc(3 * ep + 150);
      check("rises", rises > r0 + 1, 1'b1);
      check("period", period, ep);
      check("high", highLen, eh);
   endtask
   // Gate, reopen, then power down and back, on internal /4, D=3
   task automatic gate_and_pd();
      // Drop enable at a pulse start: that pulse must finish whole
      await(0, 1'b0);
      await(0, 1'b1);
      outputEnable <= 1'b0;
      await(0, 1'b0);
      r0 = rises;
      hi = 0;
      tog = 0;
      repeat (300) begin
         cyc(1);
         hi += ioOut;
         tog += refClockOut;
      end
      check("gated high", hi, 0);
      check("ref runs", tog > 0, 1'b1);
      check("last pulse", highLen, 32);
      outputEnable <= 1'b1;
      await(0, 1'b1);
      check("enable delay", n >= 31 && n <= 70, 1'b1);
      powerdownOrRefPin <= 1'b0;
      await(1, 1'b0);
      cyc(2);
      check("pd main oe", ioOe, 1'b0);
      check("pd ref oe", refOutOe, 1'b0);
      check("pd pulse", highLen, 32);
      powerdownOrRefPin <= 1'b1;
      r0 = rises;
      await(1, 1'b1);
      cyc(400);
      check("resume", rises > r0 + 1, 1'b1);
   endtask
   // Select pin moves internal /4 to external and back, D=3
   task automatic select_switch();
      powerdownOrRefPin <= 1'b0;
      cyc(400);
      check("to external", period, 36);
      powerdownOrRefPin <= 1'b1;
      cyc(600);
      check("to internal", period, 96);
   endtask
   initial begin
      power_up(1'b0);
      run_case(9'h010, 9'h001, 1'b1, 96, 32);
      gate_and_pd();
      run_case(9'h018, 9'h001, 1'b1, 48, 16);
      run_case(9'h014, 9'h001, 1'b1, 24, 8);
      run_case(9'h014, 9'h000, 1'b1, 16, 8);
      run_case(9'h014, 9'h1FF, 1'b1, 4104, 2048);
      run_case(9'h012, 9'h001, 1'b1, 8, 4);
      run_case(9'h011, 9'h001, 1'b1, 36, 12);
      run_case(9'h013, 9'h001, 1'b1, 12, 6);
      run_case(9'h000, 9'h001, 1'b1, 96, 32);
      select_switch();
      run_case(9'h020, 9'h001, 1'b0, 36, 12);
      shift_frame({9'h014, 9'h000});
      power_up(1'b0);
      cyc(300);
      check("op mode refuses", period, 36);
      finish_test();
   end
endmodule
`default_nettype wire
